// ### verif/wwd_core_tb.sv
// Self-checking bench for the windowed watchdog core
`timescale 1ns/1ps
module tb;
   localparam int DIV = 4;
   logic                ref_clk_i;
   logic                resetn_i;
   logic                cmd_wr_i;
   logic [7:0]          cmd_data_i;
   logic [1:0]          exception_level_i;
   logic                stop_mode_i;
   logic                cfg_wr_i;
   wwd_pkg::wwd_cfg_t   cfg_d;
   logic                cause_clr_i;
   wwd_pkg::wwd_cfg_t   cfg_o;
   logic                ptr_o;
   logic [15:0]         count_o;
   logic                irq_o;
   logic                sys_reset_o;
   wwd_pkg::wwd_cause_t cause_o;
   int                  err_total;
   int                  compares;
   int                  irq_cnt;
   int                  n;
   logic [15:0]         tgt;
   logic [15:0]         held;

   wwd_core #(.DIV(DIV)) i_wwd_core (
      .ref_clk_i                (ref_clk_i),
      .resetn_i                 (resetn_i),
      .cmd_wr_i                 (cmd_wr_i),
      .cmd_data_i               (cmd_data_i),
      .exception_level_i        (exception_level_i),
      .stop_mode_i              (stop_mode_i),
      .cfg_wr_i                 (cfg_wr_i),
      .cfg_data_i               (cfg_d),
      .cause_clr_i              (cause_clr_i),
      .cfg_o                    (cfg_o),
      .clear_sequence_pointer_o (ptr_o),
      .count_o                  (count_o),
      .irq_o                    (irq_o),
      .sys_reset_o              (sys_reset_o),
      .reset_cause_reg_o        (cause_o)
   );

   // ==========================================================
   // Clock and interrupt pulse counter
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      if (resetn_i !== 1'b1) irq_cnt <= 0;
      else if (irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   // ==========================================================
   // Access tasks
   task automatic close_out();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic do_reset();
      @(negedge ref_clk_i) resetn_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      resetn_i = 1'b1;
   endtask

   task automatic wr_cmd(input logic [7:0] d);
      @(negedge ref_clk_i) cmd_wr_i = 1'b1;
      cmd_data_i = d;
      @(negedge ref_clk_i) cmd_wr_i = 1'b0;
   endtask

   // Two back-to-back writes form one clear sequence
   task automatic clr_seq();
      @(negedge ref_clk_i) cmd_wr_i = 1'b1;
      cmd_data_i = 8'h5A;
      @(negedge ref_clk_i) cmd_data_i = 8'hA5;
      @(negedge ref_clk_i) cmd_wr_i = 1'b0;
   endtask

   task automatic wr_cfg(input logic [1:0] w, input logic [2:0] p);
      @(negedge ref_clk_i) cfg_wr_i = 1'b1;
      cfg_d.window_sel = w;
      cfg_d.period_sel = p;
      @(negedge ref_clk_i) cfg_wr_i = 1'b0;
   endtask

   // Waits for irq (0), system reset (1) or count target (2)
   task automatic wait_cond(input int sel, input int lim, output int k);
      k = 0;
      while (!((sel == 0 && irq_o === 1'b1) ||
               (sel == 1 && sys_reset_o === 1'b1) ||
               (sel == 2 && count_o === tgt)) && k < lim) begin
         @(negedge ref_clk_i);
         k++;
      end
      if (k >= lim) begin
         err_total++;
         $display("CHECK FAILED %0t wait ran out", $time);
         close_out();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      err_total = 0; compares = 0; tgt = 16'h0000;
      resetn_i = 1'b0; cmd_wr_i = 1'b0; cmd_data_i = 8'h00;
      exception_level_i = 2'h0; stop_mode_i = 1'b0; cfg_wr_i = 1'b0;
      cfg_d = '0; cause_clr_i = 1'b0;
      do_reset();
      chk(cfg_o === 5'h06 && ptr_o === 1'b0 && count_o === 16'h0000 &&
          sys_reset_o === 1'b0 && cause_o === 2'h0, "reset values");
      wr_cmd(8'h00); chk(ptr_o === 1'b1, "pointer toggle");
      wr_cmd(8'h33); chk(ptr_o === 1'b0, "pointer back");
      repeat (40) @(negedge ref_clk_i);
      chk(count_o > 16'h0008 && count_o < 16'h000E, "count up");
      clr_seq(); chk(count_o === 16'h0000 && ptr_o === 1'b0, "clear");
      stop_mode_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      held = count_o;
      repeat (40) @(negedge ref_clk_i);
      chk(count_o === held, "stop holds count");
      stop_mode_i = 1'b0;
      repeat (20) @(negedge ref_clk_i);
      chk(count_o !== held, "count resumes");
      wr_cmd(8'h5A); wr_cmd(8'h5A); chk(ptr_o === 1'b0, "second key");
      wr_cmd(8'hA5); chk(count_o !== 16'h0000 && ptr_o === 1'b1, "lone A5");
      wr_cmd(8'h00);
      exception_level_i = 2'h2;
      clr_seq(); chk(count_o !== 16'h0000, "level 2 blocks clear");
      exception_level_i = 2'h1;
      clr_seq(); chk(count_o === 16'h0000, "level 1 clears");
      // Window off: interrupt, then reset one period later, for the seven shortest periods
      for (int p = 0; p < 7; p++) begin
         do_reset(); wr_cfg(2'h0, 3'(p)); wr_cmd(8'h00);
         wait_cond(0, 40000, n);
         chk(ptr_o === 1'b0 && count_o === 16'h0000 &&
             sys_reset_o === 1'b0, "first overflow");
         wait_cond(1, 40000, n);
         chk(n == int'(wwd_pkg::PER_TICKS[p]) * DIV && irq_cnt == 1 &&
             cause_o === 2'b10, "second overflow");
      end
      cause_clr_i = 1'b1;
      @(negedge ref_clk_i) cause_clr_i = 1'b0;
      chk(cause_o === 2'b00 && sys_reset_o === 1'b1, "cause clear");
      wr_cfg(2'h0, 3'h7); chk(cfg_o === 5'h07, "longest period");
      // Window on: overflow resets at once, no interrupt
      do_reset(); wr_cfg(2'h1, 3'h4);
      wait_cond(1, 1000, n);
      chk(cause_o === 2'b10 && irq_cnt == 0 && n > 480, "win ovf");
      for (int w = 1; w < 4; w++) begin
         do_reset(); wr_cfg(2'(w), 3'h4); clr_seq();
         chk(sys_reset_o === 1'b1 && cause_o === 2'b01, "closed");
         do_reset(); wr_cfg(2'(w), 3'h4);
         tgt = 16'h0028;
         wait_cond(2, 1000, n); clr_seq();
         chk(sys_reset_o === (w != 1) && (w != 1 || count_o === 16'h0000),
             "mid window");
      end
      do_reset(); wr_cfg(2'h2, 3'h3); clr_seq();
      chk(sys_reset_o === 1'b0 && count_o === 16'h0000, "short");
      close_out();
   end
endmodule

// ### verilog/wwd_core.sv
// Windowed watchdog timer core
// Operation
// - Clear needs 0x5A at pointer 0, then 0xA5 at pointer 1, window open.
// - Pointer returns to 0 on system reset and on each overflow.
// - Every clear command write inverts the pointer, except in an overflow cycle.
// - 0x5A written at pointer 1 is not accepted; pointer still toggles.
// - 0xA5 without accepted 0x5A or at pointer 0 does not clear.
// - Counter counts up from zero after reset release.
// - Counter halts in STOP mode.
// - Window off, first overflow raises interrupt, not reset.
// - Counter wraps to zero on overflow; keeps counting unless that overflow requests reset.
// - Window off, second overflow resets and sets overflow flag.
// - Three-bit select picks eight periods from 7.8 ms to 8000 ms.
// - Window off, reset at twice the period; clear allowed at any count.
// - Window on, first overflow resets at once, no interrupt.
// - Window on, clear in closed period resets, sets invalid flag.
// - Mode 1 opens about 75 percent, mode 2 about 50 percent.
// - Periods of 62.5 ms or shorter disable the window function.
// - Clearing has no effect at exception level 2.
// - Window select 00 off, 01 mode 1, 10 and 11 mode 2.
`timescale 1ns/1ps
module wwd_core #(
   parameter int DIV = wwd_pkg::WDCLK_DIV
) (
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   input  wire logic         cmd_wr_i,
   input  wire logic [7:0]   cmd_data_i,
   input  wire logic [1:0]   exception_level_i,
   input  wire logic         stop_mode_i,
   input  wire logic         cfg_wr_i,
   input  wwd_pkg::wwd_cfg_t cfg_data_i,
   input  wire logic         cause_clr_i,
   output wwd_pkg::wwd_cfg_t cfg_o,
   output logic              clear_sequence_pointer_o,
   output logic [15:0]       count_o,
   output logic              irq_o,
   output logic              sys_reset_o,
   output wwd_pkg::wwd_cause_t reset_cause_reg_o
);
   // ==========================================================
   // State
   logic                 ptr_reg;
   logic                 armed_reg;
   logic [15:0]          cnt_reg;
   logic                 ovf_once_reg;
   logic                 irq_reg;
   logic                 rst_reg;
   wwd_pkg::wwd_cfg_t    cfg_reg;
   wwd_pkg::wwd_cause_t  cause_reg;

   logic        tick;
   logic        run;
   logic [15:0] period;
   logic [15:0] open_at;
   logic        win_on;
   logic        ovf;
   logic        in_window;
   logic        level_ok;
   logic        first_ok;
   logic        second_ok;
   logic        clear_ok;
   logic        clear_bad;
   logic        ovf_reset;
   logic [15:0] cnt_next;

   // ==========================================================
   // Sub-blocks
   assign run = !stop_mode_i && !rst_reg;

   wwd_tick_gen #(.DIV(DIV)) u_tick (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .run_i     (run),
      .tick_o    (tick)
   );

   wwd_window_calc u_win (
      .cfg_i     (cfg_reg),
      .period_o  (period),
      .open_at_o (open_at),
      .win_on_o  (win_on)
   );

   // ==========================================================
   // Decode of clear sequence and overflow
   assign ovf       = tick && (cnt_reg == period - 16'h0001);
   assign in_window = (cnt_reg >= open_at);
   assign level_ok  = exception_level_i != wwd_pkg::EXCEPTION_LEVEL_IRQ;
   assign first_ok  = cmd_wr_i && !ptr_reg &&
                      (cmd_data_i == wwd_pkg::CLR_KEY_FIRST);
   assign second_ok = cmd_wr_i && ptr_reg && armed_reg &&
                      (cmd_data_i == wwd_pkg::CLR_KEY_SECOND) &&
                      level_ok && !rst_reg;
   assign clear_ok  = second_ok && (in_window || !win_on);
   assign clear_bad = second_ok && win_on && !in_window;
   assign ovf_reset = ovf && (win_on || ovf_once_reg);
   // Wrap at overflow, restart on clear, else count per tick
   assign cnt_next  = (clear_ok || ovf) ? 16'h0000 :
                      tick ? cnt_reg + 16'h0001 : cnt_reg;

   // ==========================================================
   // Pointer and first-step latch
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ptr_reg   <= 1'b0;
         armed_reg <= 1'b0;
      end else if (ovf) begin
         ptr_reg   <= 1'b0;
         armed_reg <= 1'b0;
      end else if (cmd_wr_i) begin
         ptr_reg   <= !ptr_reg;
         armed_reg <= first_ok;
      end
   end

   // Counter starts from zero at reset release
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // First-overflow memory and interrupt pulse
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovf_once_reg <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         irq_reg <= ovf && !win_on && !ovf_once_reg;
         if (clear_ok) begin
            ovf_once_reg <= 1'b0;
         end else if (ovf && !win_on) begin
            ovf_once_reg <= 1'b1;
         end
      end
   end

   // System reset request, held until external reset arrives
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_reg <= 1'b0;
      end else if (ovf_reset || clear_bad) begin
         rst_reg <= 1'b1;
      end
   end

   // Reset cause flags: set wins over software clear
   // (these would live on a power-on reset domain in a full chip)
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cause_reg <= '0;
      end else begin
         cause_reg.overflow_reset_flag <= ovf_reset ||
            (cause_reg.overflow_reset_flag && !cause_clr_i);
         cause_reg.invalid_clear_reset_flag <= clear_bad ||
            (cause_reg.invalid_clear_reset_flag && !cause_clr_i);
      end
   end

   // Configuration register
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_reg.period_sel <= wwd_pkg::PSEL_RESET;
         cfg_reg.window_sel <= wwd_pkg::WSEL_RESET;
      end else if (cfg_wr_i) begin
         cfg_reg <= cfg_data_i;
      end
   end

   // ==========================================================
   // Outputs
   assign cfg_o                    = cfg_reg;
   assign clear_sequence_pointer_o = ptr_reg;
   assign count_o                  = cnt_reg;
   assign irq_o                    = irq_reg;
   assign sys_reset_o              = rst_reg;
   assign reset_cause_reg_o        = cause_reg;

   // ==========================================================
   // Assertions
   property p_ptr_toggle;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (cmd_wr_i && !ovf) |=> (ptr_reg != $past(ptr_reg));
   endproperty
   a_ptr_toggle: assert property (p_ptr_toggle)
      else $error("pointer did not toggle on write");

   property p_ptr_ovf;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      ovf |=> !ptr_reg;
   endproperty
   a_ptr_ovf: assert property (p_ptr_ovf)
      else $error("pointer not zero after overflow");

   sequence s_first;
      cmd_wr_i && !ptr_reg && cmd_data_i == 8'h5A && !ovf;
   endsequence
   sequence s_second;
      cmd_wr_i && cmd_data_i == 8'hA5 && level_ok && !ovf && !rst_reg &&
      (!win_on || in_window);
   endsequence
   property p_clear;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_first ##1 s_second |=> cnt_reg == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("valid clear sequence did not clear");

   property p_bad_first;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (cmd_wr_i && ptr_reg && !ovf) |=> !armed_reg;
   endproperty
   a_bad_first: assert property (p_bad_first)
      else $error("first key accepted at pointer one");

   property p_no_clear_lvl2;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (exception_level_i == 2'h2 && !ovf && !tick) |=>
         cnt_reg == $past(cnt_reg);
   endproperty
   a_no_clear_lvl2: assert property (p_no_clear_lvl2)
      else $error("counter changed at level two");

   property p_stop;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      stop_mode_i |=> cnt_reg == $past(cnt_reg);
   endproperty
   a_stop: assert property (p_stop)
      else $error("counter moved in stop mode");

   property p_irq;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (ovf && !win_on && !ovf_once_reg) |=> irq_o && !sys_reset_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("first overflow did not raise interrupt");

   property p_second_ovf;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (ovf && ovf_once_reg) |=>
         sys_reset_o && reset_cause_reg_o.overflow_reset_flag;
   endproperty
   a_second_ovf: assert property (p_second_ovf)
      else $error("second overflow did not reset");

   property p_win_ovf;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (ovf && win_on) |=> sys_reset_o && !irq_o;
   endproperty
   a_win_ovf: assert property (p_win_ovf)
      else $error("window overflow did not reset");

   property p_invalid;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      clear_bad |=> sys_reset_o &&
         reset_cause_reg_o.invalid_clear_reset_flag;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("closed window clear did not reset");

   property p_short_nowin;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (cfg_reg.period_sel <= 3'h3) |-> !win_on;
   endproperty
   a_short_nowin: assert property (p_short_nowin)
      else $error("window active on short period");

   // Cycles spent at zero while running; a stuck counter runs this up
   logic [15:0] zero_run_reg;
   logic [15:0] zero_run_next;
   assign zero_run_next = (!run || cnt_reg != 16'h0000) ? 16'h0000 :
                          (zero_run_reg == 16'hFFFF) ? zero_run_reg :
                          zero_run_reg + 16'h0001;

   // Zero-run counter
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         zero_run_reg <= 16'h0000;
      end else begin
         zero_run_reg <= zero_run_next;
      end
   end

   property p_wrap;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      ((ovf && !ovf_reset) |=> cnt_reg == 16'h0000) and
      (zero_run_reg <= 16'(2 * DIV));
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not resume after wrap");
endmodule

// ### verilog/wwd_pkg.sv
// Shared constants and types for the windowed watchdog timer
package wwd_pkg;

   // ==========================================================
   // Clear command values
   localparam logic [7:0] CLR_KEY_FIRST  = 8'h5A;
   localparam logic [7:0] CLR_KEY_SECOND = 8'hA5;

   // ==========================================================
   // Configuration field layout and reset values
   localparam int         PSEL_W        = 3;
   localparam int         WSEL_W        = 2;
   localparam int         CNT_W         = 16;
   localparam logic [2:0] PSEL_RESET    = 3'h6;
   localparam logic [1:0] WSEL_RESET    = 2'h0;
   localparam logic [2:0] PSEL_MAX_NOWIN = 3'h3;   // 62.5 ms and shorter
   localparam logic [1:0] EXCEPTION_LEVEL_IRQ    = 2'h2;

   // ==========================================================
   // Watchdog count clock and period lengths in watchdog ticks
   localparam int WDCLK_HZ = 1024;
   localparam int REF_HZ   = 10_000_000;
   localparam int WDCLK_DIV = REF_HZ / WDCLK_HZ;  // ref cycles per tick
   // Tick counts for 7.8,15.6,31.3,62.5,125,500,2000,8000 ms
   localparam logic [15:0] PER_TICKS [8] = '{
      16'h0008, 16'h0010, 16'h0020, 16'h0040,
      16'h0080, 16'h0200, 16'h0800, 16'h2000};

   // ==========================================================
   // Window modes
   typedef enum logic [1:0] {
      WWD_WIN_OFF = 2'b00,
      WWD_WIN_75  = 2'b01,
      WWD_WIN_50  = 2'b10
   } wwd_win_t;

   // Configuration carrier
   typedef struct packed {
      logic [WSEL_W-1:0] window_sel;
      logic [PSEL_W-1:0] period_sel;
   } wwd_cfg_t;

   // Reset cause carrier
   typedef struct packed {
      logic overflow_reset_flag;
      logic invalid_clear_reset_flag;
   } wwd_cause_t;

endpackage

// ### verilog/wwd_tick_gen.sv
// Divider that makes the watchdog count clock tick from the reference
`timescale 1ns/1ps
module wwd_tick_gen #(
   parameter int DIV = wwd_pkg::WDCLK_DIV
) (
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic run_i,
   output logic      tick_o
);
   localparam logic [15:0] LAST = 16'(DIV - 1);
   logic [15:0] div_reg;
   logic [15:0] div_next;

   // Count while running, one-cycle tick at wrap
   assign tick_o   = run_i && (div_reg == LAST);
   assign div_next = tick_o ? 16'h0000 : div_reg + 16'h0001;

   // Divider state
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_reg <= 16'h0000;
      end else if (run_i) begin
         div_reg <= div_next;
      end
   end
endmodule

// ### verilog/wwd_window_calc.sv
// Decodes period select and window select into thresholds
`timescale 1ns/1ps
module wwd_window_calc (
   input  wwd_pkg::wwd_cfg_t cfg_i,
   output logic [15:0]       period_o,
   output logic [15:0]       open_at_o,
   output logic              win_on_o
);
   logic [15:0] per;
   logic        long_per;
   wwd_pkg::wwd_win_t mode;

   // Period lookup and effective window mode
   assign per      = wwd_pkg::PER_TICKS[cfg_i.period_sel];
   assign long_per = cfg_i.period_sel > wwd_pkg::PSEL_MAX_NOWIN;
   assign mode     = (cfg_i.window_sel == 2'b00) ? wwd_pkg::WWD_WIN_OFF :
                     (cfg_i.window_sel == 2'b01) ? wwd_pkg::WWD_WIN_75 :
                     wwd_pkg::WWD_WIN_50;
   assign win_on_o = long_per && (mode != wwd_pkg::WWD_WIN_OFF);
   assign period_o = per;
   // Closed part first, open part up to overflow
   assign open_at_o = !win_on_o ? 16'h0000 :
                      (mode == wwd_pkg::WWD_WIN_75) ? (per >> 2) :
                      (per >> 1);
endmodule
